// ---- xma_defines.svh ----
/*
  Offsets, field positions, reset values and timing counts of the
  extended memory ALU block. Assumes inclusion by bare name.
*/
`ifndef XMA_DEFINES_SVH
`define XMA_DEFINES_SVH

// Register byte offsets on the AHB-Lite port
`define XMA_OFF_CMD 8'h00
`define XMA_OFF_ACC 8'h04
`define XMA_OFF_FLAGS 8'h08
`define XMA_OFF_MADDR 8'h0c
`define XMA_OFF_MDATA 8'h10
`define XMA_OFF_STATUS 8'h14

// Command word fields
`define XMA_CMD_OP_LSB 0
`define XMA_CMD_OP_MSB 4
`define XMA_CMD_BIT_LSB 8
`define XMA_CMD_BIT_MSB 10
`define XMA_CMD_ADDR_LSB 16
`define XMA_CMD_ADDR_MAX 12

// Flag register bit positions
`define XMA_FLG_C 0
`define XMA_FLG_AC 1
`define XMA_FLG_Z 2
`define XMA_FLG_OV 3
`define XMA_FLG_SC 4
`define XMA_FLG_CZ 5

// Status register bit positions
`define XMA_STS_BUSY 0
`define XMA_STS_SKIP 1
`define XMA_STS_ILL 2

// Reset values
`define XMA_ACC_RST 8'h00
`define XMA_FLAGS_RST 6'h00

// Dummy cycles after the execute cycle of a skip operation
`define XMA_SKIP_DUMMY 2'h2

`endif

// ---- xma_pkg.sv ----
/*
  Types of the extended memory ALU block: opcodes, sequencer
  states and the subtractor result.
  Assumes nothing of its surroundings.
*/
package xma_pkg;

  typedef enum logic [4:0] {
    OP_MOVE_ACC_TO_MEMORY = 5'h00,
    OP_OR_TO_ACCUMULATOR = 5'h01,
    OP_OR_TO_MEMORY = 5'h02,
    OP_ROTATE_LEFT_MEMORY = 5'h03,
    OP_ROTATE_LEFT_TO_ACC = 5'h04,
    OP_ROTATE_LEFT_CARRY_MEM = 5'h05,
    OP_ROTATE_LEFT_CARRY_ACC = 5'h06,
    OP_ROTATE_RIGHT_MEMORY = 5'h07,
    OP_ROTATE_RIGHT_TO_ACC = 5'h08,
    OP_ROTATE_RIGHT_CARRY_MEM = 5'h09,
    OP_ROTATE_RIGHT_CARRY_ACC = 5'h0a,
    OP_SUBTRACT_BORROW_TO_ACC = 5'h0b,
    OP_SUBTRACT_BORROW_TO_MEM = 5'h0c,
    OP_SUBTRACT_TO_ACCUMULATOR = 5'h0d,
    OP_SUBTRACT_TO_MEMORY = 5'h0e,
    OP_DECREMENT_SKIP_ZERO = 5'h0f,
    OP_DECREMENT_SKIP_ZERO_ACC = 5'h10,
    OP_INCREMENT_SKIP_ZERO = 5'h11,
    OP_INCREMENT_SKIP_ZERO_ACC = 5'h12,
    OP_SET_MEMORY_ONES = 5'h13,
    OP_SET_MEMORY_BIT = 5'h14,
    OP_SKIP_IF_BIT_SET = 5'h15,
    OP_SKIP_IF_NONZERO = 5'h16,
    OP_NIBBLE_EXCHANGE = 5'h17
  } xma_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DUMMY = 3'b100
  } xma_state_t;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic ac;
    logic ov;
  } xma_sub_t;

endpackage

// ---- xma_core.sv ----
/*
  Execution datapath for the extended memory instructions: move,
  OR, rotates, subtracts, set, skip tests and nibble exchange, with
  its own byte-wide data memory, accumulator and status flags, all
  reached over an AHB-Lite slave port.
  Assumes single whole-word transfers and one slave on the bus, so
  HREADY is this block's own HREADYOUT.
*/
// The AHB-Lite slave port and the placing of the registers were decided locally.
// Overview of operation
// - Any memory address reached directly, no banking
// - Move copies accumulator to memory, flags kept
// - OR to accumulator or memory, Z only
// - Rotate left, bit 7 into bit 0
// - Rotate left through carry, carry only changes
// - Rotate right, bit 0 into bit 7
// - Rotate right through carry, carry only changes
// - Accumulator rotates leave memory byte unchanged
// - Subtract with borrow: acc minus mem minus not-carry
// - Plain subtract: acc minus mem
// - Subtract carry means no borrow; six flags update
// - Skip operations take three cycles
// - Decrement memory, skip when result zero
// - Decrement into accumulator, memory kept, skip zero
// - Increment memory, skip when result zero
// - Increment into accumulator, memory kept, skip zero
// - Set byte writes all ones, flags kept
// - Set bit forces one selected bit only
// - Bit test skips when selected bit is one
// - Byte test rewrites byte, skips when nonzero
// - Nibble exchange swaps halves in place
`include "xma_defines.svh"

module xma_core
  import xma_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic BUSY,
  output logic OP_DONE,
  output logic SKIP_TAKEN
);

  generate
    if (ADDR_W < 1 || ADDR_W > `XMA_CMD_ADDR_MAX) begin : g_chk
      $error("ADDR_W must lie between 1 and 12");
    end
  endgenerate

  localparam int DEPTH = 1 << ADDR_W;

  function automatic xma_sub_t xma_sub(input logic [7:0] a,
                                       input logic [7:0] m,
                                       input logic b);
    logic [8:0] full;
    logic [4:0] low;
    xma_sub_t r;
    full = {1'b0, a} - {1'b0, m} - {8'h00, b};
    low = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, b};
    r.res = full[7:0];
    r.c = ~full[8];
    r.ac = ~low[4];
    r.ov = (a[7] ^ m[7]) & (a[7] ^ full[7]);
    return r;
  endfunction

  function automatic logic [7:0] xma_step(input logic [7:0] v,
                                          input logic up);
    return up ? v + 8'h01 : v - 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State

  // Memory holds data only; its contents are undefined after reset
  logic [7:0] mem [DEPTH];

  xma_state_t st_reg;
  xma_state_t st_next;
  logic [1:0] dcnt_reg;
  logic [1:0] dcnt_next;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic [5:0] flags_reg;
  logic [5:0] flags_next;
  logic [4:0] cmd_op_reg;
  logic [2:0] cmd_bit_reg;
  logic [ADDR_W-1:0] cmd_addr_reg;
  logic [ADDR_W-1:0] maddr_reg;
  logic skip_reg;
  logic skip_next;
  logic ill_reg;
  logic ill_next;
  logic done_reg;
  logic dp_pend_reg;
  logic dp_write_reg;
  logic [7:0] dp_addr_reg;
  logic [31:0] hrdata_reg;
  logic hready_reg;
  logic busy_reg;

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  wire st_idle = (st_reg == ST_IDLE);
  wire st_exec = (st_reg == ST_EXEC);
  wire st_dummy = (st_reg == ST_DUMMY);
  wire ap_take = HSEL & HTRANS[1] & HREADY;
  // Bus waits while an operation runs, so it never races the engine
  wire bus_act = dp_pend_reg & st_idle;
  wire bus_wr = bus_act & dp_write_reg;
  wire bus_rd = bus_act & ~dp_write_reg;
  wire hit_cmd = (dp_addr_reg == `XMA_OFF_CMD);
  wire hit_acc = (dp_addr_reg == `XMA_OFF_ACC);
  wire hit_flags = (dp_addr_reg == `XMA_OFF_FLAGS);
  wire hit_maddr = (dp_addr_reg == `XMA_OFF_MADDR);
  wire hit_mdata = (dp_addr_reg == `XMA_OFF_MDATA);
  wire hit_status = (dp_addr_reg == `XMA_OFF_STATUS);
  wire cmd_start = bus_wr & hit_cmd;

  wire [4:0] wr_op = HWDATA[`XMA_CMD_OP_MSB:`XMA_CMD_OP_LSB];
  wire [2:0] wr_bit = HWDATA[`XMA_CMD_BIT_MSB:`XMA_CMD_BIT_LSB];
  wire [ADDR_W-1:0] wr_addr =
    HWDATA[`XMA_CMD_ADDR_LSB +: ADDR_W];

  wire [31:0] cmd_rd;
  // Pad width never reaches zero, even at the widest address
  assign cmd_rd = {{(32 - `XMA_CMD_ADDR_LSB - ADDR_W){1'b0}},
                   cmd_addr_reg, 5'h00, cmd_bit_reg, 3'h0, cmd_op_reg};
  wire [31:0] status_rd = {29'h0, ill_reg, skip_reg, ~st_idle};
  wire [31:0] maddr_rd = {{(32 - ADDR_W){1'b0}}, maddr_reg};
  wire [31:0] rd_mux =
    hit_cmd ? cmd_rd :
    hit_acc ? {24'h0, acc_reg} :
    hit_flags ? {26'h0, flags_reg} :
    hit_maddr ? maddr_rd :
    hit_mdata ? {24'h0, mem[maddr_reg]} :
    hit_status ? status_rd :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////
  // Datapath

  // Whole flat address space, no bank register involved
  wire [7:0] m = mem[cmd_addr_reg];
  wire [7:0] a = acc_reg;
  wire cin = flags_reg[`XMA_FLG_C];
  wire [7:0] rot_l = {m[6:0], m[7]};
  wire [7:0] rot_lc = {m[6:0], cin};
  wire [7:0] rot_r = {m[0], m[7:1]};
  wire [7:0] rot_rc = {cin, m[7:1]};
  wire [7:0] dec_v = xma_step(m, 1'b0);
  wire [7:0] inc_v = xma_step(m, 1'b1);
  wire [7:0] swap_v = {m[3:0], m[7:4]};
  wire [7:0] bit_mask = 8'h01 << cmd_bit_reg;
  wire bit_one = |(m & bit_mask);
  // Borrow-in is the inverted carry only for the borrow variants
  wire sub_borrow = (cmd_op_reg == OP_SUBTRACT_BORROW_TO_ACC ||
                     cmd_op_reg == OP_SUBTRACT_BORROW_TO_MEM) ?
                    ~cin : 1'b0;
  wire xma_sub_t sub_v = xma_sub(a, m, sub_borrow);

  logic [7:0] res;
  logic wr_mem;
  logic wr_acc;
  logic upd_z;
  logic upd_sub;
  logic upd_c;
  logic c_val;
  logic chain;
  logic is_skip;
  logic skip_cond;
  logic illegal;

  always_comb begin
    res = m;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    upd_z = 1'b0;
    upd_sub = 1'b0;
    upd_c = 1'b0;
    c_val = cin;
    chain = 1'b0;
    is_skip = 1'b0;
    skip_cond = 1'b0;
    illegal = 1'b0;
    case (cmd_op_reg)
      OP_MOVE_ACC_TO_MEMORY: begin
        res = a;
        wr_mem = 1'b1;
      end
      OP_OR_TO_ACCUMULATOR: begin
        res = a | m;
        wr_acc = 1'b1;
        upd_z = 1'b1;
      end
      OP_OR_TO_MEMORY: begin
        res = a | m;
        wr_mem = 1'b1;
        upd_z = 1'b1;
      end
      OP_ROTATE_LEFT_MEMORY: begin
        res = rot_l;
        wr_mem = 1'b1;
      end
      OP_ROTATE_LEFT_TO_ACC: begin
        res = rot_l;
        wr_acc = 1'b1;
      end
      OP_ROTATE_LEFT_CARRY_MEM: begin
        res = rot_lc;
        wr_mem = 1'b1;
        upd_c = 1'b1;
        c_val = m[7];
      end
      OP_ROTATE_LEFT_CARRY_ACC: begin
        res = rot_lc;
        wr_acc = 1'b1;
        upd_c = 1'b1;
        c_val = m[7];
      end
      OP_ROTATE_RIGHT_MEMORY: begin
        res = rot_r;
        wr_mem = 1'b1;
      end
      OP_ROTATE_RIGHT_TO_ACC: begin
        res = rot_r;
        wr_acc = 1'b1;
      end
      OP_ROTATE_RIGHT_CARRY_MEM: begin
        res = rot_rc;
        wr_mem = 1'b1;
        upd_c = 1'b1;
        c_val = m[0];
      end
      OP_ROTATE_RIGHT_CARRY_ACC: begin
        res = rot_rc;
        wr_acc = 1'b1;
        upd_c = 1'b1;
        c_val = m[0];
      end
      OP_SUBTRACT_BORROW_TO_ACC: begin
        res = sub_v.res;
        wr_acc = 1'b1;
        upd_sub = 1'b1;
        chain = 1'b1;
      end
      OP_SUBTRACT_BORROW_TO_MEM: begin
        res = sub_v.res;
        wr_mem = 1'b1;
        upd_sub = 1'b1;
        chain = 1'b1;
      end
      OP_SUBTRACT_TO_ACCUMULATOR: begin
        res = sub_v.res;
        wr_acc = 1'b1;
        upd_sub = 1'b1;
      end
      OP_SUBTRACT_TO_MEMORY: begin
        res = sub_v.res;
        wr_mem = 1'b1;
        upd_sub = 1'b1;
      end
      OP_DECREMENT_SKIP_ZERO: begin
        res = dec_v;
        wr_mem = 1'b1;
        is_skip = 1'b1;
        skip_cond = (dec_v == 8'h00);
      end
      OP_DECREMENT_SKIP_ZERO_ACC: begin
        res = dec_v;
        wr_acc = 1'b1;
        is_skip = 1'b1;
        skip_cond = (dec_v == 8'h00);
      end
      OP_INCREMENT_SKIP_ZERO: begin
        res = inc_v;
        wr_mem = 1'b1;
        is_skip = 1'b1;
        skip_cond = (inc_v == 8'h00);
      end
      OP_INCREMENT_SKIP_ZERO_ACC: begin
        res = inc_v;
        wr_acc = 1'b1;
        is_skip = 1'b1;
        skip_cond = (inc_v == 8'h00);
      end
      OP_SET_MEMORY_ONES: begin
        res = 8'hff;
        wr_mem = 1'b1;
      end
      OP_SET_MEMORY_BIT: begin
        res = m | bit_mask;
        wr_mem = 1'b1;
      end
      OP_SKIP_IF_BIT_SET: begin
        is_skip = 1'b1;
        skip_cond = bit_one;
      end
      OP_SKIP_IF_NONZERO: begin
        res = m;
        wr_mem = 1'b1;
        is_skip = 1'b1;
        skip_cond = (m != 8'h00);
      end
      OP_NIBBLE_EXCHANGE: begin
        res = swap_v;
        wr_mem = 1'b1;
      end
      default: begin
        // Unknown codes do nothing but are reported in status
        illegal = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next values

  wire res_zero = (res == 8'h00);

  always_comb begin
    flags_next = flags_reg;
    if (bus_wr && hit_flags) begin
      flags_next = HWDATA[5:0];
    end else if (st_exec) begin
      if (upd_z || upd_sub) begin
        flags_next[`XMA_FLG_Z] = res_zero;
      end
      if (upd_c) begin
        flags_next[`XMA_FLG_C] = c_val;
      end
      if (upd_sub) begin
        // No borrow leaves carry set, a borrow clears it
        flags_next[`XMA_FLG_C] = sub_v.c;
        flags_next[`XMA_FLG_AC] = sub_v.ac;
        flags_next[`XMA_FLG_OV] = sub_v.ov;
        flags_next[`XMA_FLG_SC] = sub_v.res[7] ^ sub_v.ov;
        // Chained zero keeps a multi-byte borrow chain's zero state
        flags_next[`XMA_FLG_CZ] = chain ?
          (res_zero & flags_reg[`XMA_FLG_CZ]) : res_zero;
      end
    end
  end

  assign acc_next = (bus_wr && hit_acc) ? HWDATA[7:0] :
                    (st_exec && wr_acc) ? res : acc_reg;

  wire mem_we = (bus_wr & hit_mdata) | (st_exec & wr_mem);
  wire [ADDR_W-1:0] mem_wa = st_exec ? cmd_addr_reg : maddr_reg;
  wire [7:0] mem_wd = st_exec ? res : HWDATA[7:0];

  // A skip op always spends two dummy cycles after execute
  always_comb begin
    st_next = st_reg;
    dcnt_next = dcnt_reg;
    case (st_reg)
      ST_IDLE: begin
        if (cmd_start) begin
          st_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (is_skip) begin
          st_next = ST_DUMMY;
          dcnt_next = `XMA_SKIP_DUMMY;
        end else begin
          st_next = ST_IDLE;
        end
      end
      ST_DUMMY: begin
        dcnt_next = dcnt_reg - 2'h1;
        if (dcnt_reg == 2'h1) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  assign skip_next = cmd_start ? 1'b0 :
                     st_exec ? (is_skip & skip_cond) : skip_reg;
  assign ill_next = cmd_start ? 1'b0 : st_exec ? illegal : ill_reg;
  wire done_now = (st_exec & ~is_skip) |
                  (st_dummy & (dcnt_reg == 2'h1));

  ////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CORE_CLK) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      st_reg <= ST_IDLE;
      dcnt_reg <= 2'h0;
      acc_reg <= `XMA_ACC_RST;
      flags_reg <= `XMA_FLAGS_RST;
      skip_reg <= 1'b0;
      ill_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      // Registered copy of the state decode, so the pin has no glitch
      busy_reg <= (st_next != ST_IDLE);
      dcnt_reg <= dcnt_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      skip_reg <= skip_next;
      ill_reg <= ill_next;
      done_reg <= done_now;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      cmd_op_reg <= 5'h00;
      cmd_bit_reg <= 3'h0;
      cmd_addr_reg <= '0;
      maddr_reg <= '0;
    end else begin
      if (cmd_start) begin
        cmd_op_reg <= wr_op;
        cmd_bit_reg <= wr_bit;
        cmd_addr_reg <= wr_addr;
      end
      if (bus_wr && hit_maddr) begin
        maddr_reg <= HWDATA[ADDR_W-1:0];
      end
    end
  end

  // One wait state per transfer; more while an operation runs
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      dp_pend_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hready_reg <= 1'b1;
    end else begin
      if (ap_take) begin
        dp_pend_reg <= 1'b1;
        dp_write_reg <= HWRITE;
        dp_addr_reg <= HADDR[7:0];
        hready_reg <= 1'b0;
      end else if (bus_act) begin
        dp_pend_reg <= 1'b0;
        hready_reg <= 1'b1;
      end
      if (bus_rd) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  assign HRDATA = hrdata_reg;
  assign HREADYOUT = hready_reg;
  assign HRESP = 1'b0;
  assign BUSY = busy_reg;
  assign OP_DONE = done_reg;
  assign SKIP_TAKEN = skip_reg;

endmodule

// ---- xma_core_asserts.sv ----
/*
  Concurrent checks on the ports of xma_core: operation timing,
  skip status, bus wait and response.
  Assumes HREADY is tied to HREADYOUT and whole-word transfers.
*/
`include "xma_defines.svh"

module xma_core_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic BUSY,
  input wire logic OP_DONE,
  input wire logic SKIP_TAKEN
);
  logic dp_act;
  logic dp_wr;
  logic [7:0] dp_adr;
  logic skip_q;
  wire addr_take = HSEL & HTRANS[1] & HREADY;
  wire cmd_dp = dp_act & dp_wr & (dp_adr == `XMA_OFF_CMD);
  // Command word is still on HWDATA at the completing edge
  wire cmd_end = cmd_dp & HREADYOUT;
  wire [4:0] opc = HWDATA[4:0];
  wire is_skip = (opc >= 5'h0f && opc <= 5'h12) || opc == 5'h15 ||
                 opc == 5'h16;
  wire legal = opc <= 5'h17;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      dp_act <= 1'b0;
      dp_wr <= 1'b0;
      dp_adr <= 8'h00;
      skip_q <= 1'b0;
    end else begin
      if (addr_take) begin
        dp_act <= 1'b1;
        dp_wr <= HWRITE;
        dp_adr <= HADDR[7:0];
      end else if (HREADYOUT) begin
        dp_act <= 1'b0;
      end
      skip_q <= cmd_end & is_skip;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  ////////////////////////////////////////////////////////////////////
  a_skip_busy: assert property (
    cmd_end && is_skip |-> BUSY [*3] ##1 (!BUSY && OP_DONE))
    else $error("skip op not three busy cycles");
  a_plain_busy: assert property (
    cmd_end && legal && !is_skip |-> BUSY ##1 (!BUSY && OP_DONE))
    else $error("plain op not one busy cycle");
  a_done_once: assert property (
    OP_DONE |=> !OP_DONE)
    else $error("done pulse longer than one cycle");
  a_bus_wait: assert property (
    dp_act && BUSY && !cmd_dp |-> !HREADYOUT)
    else $error("bus answered while engine busy");
  a_bus_answer: assert property (
    dp_act |-> ##[0:5] HREADYOUT)
    else $error("bus answer too late");
  a_skip_rise: assert property (
    $rose(SKIP_TAKEN) |-> skip_q)
    else $error("skip flag rose without skip op");
  a_skip_fall: assert property (
    $fell(SKIP_TAKEN) |-> cmd_end)
    else $error("skip flag fell without command");
  a_noskip_low: assert property (
    cmd_end && !is_skip |=> !SKIP_TAKEN)
    else $error("skip flag after non-skip op");
  a_resp_okay: assert property (
    !HRESP)
    else $error("error response seen");

  c_skip_op: cover property (cmd_end && is_skip);
  c_skip_set: cover property ($rose(SKIP_TAKEN));
  c_bad_op: cover property (cmd_end && !legal);
endmodule

bind xma_core xma_core_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BUSY(BUSY),
  .OP_DONE(OP_DONE), .SKIP_TAKEN(SKIP_TAKEN));

// ---- xma_core_tb_top.sv ----
/*
  Self-checking bench of xma_core: every opcode with random and
  boundary operands over AHB-Lite, results checked by register reads.
  Assumes the design is the only slave, HREADY fed from HREADYOUT.
*/
`include "xma_defines.svh"

module xma_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rd_dp = 1'b0;
  wire [31:0] hrdata;
  wire hready, hresp, busy, op_done, skip_taken;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  integer seed = 32'h0330;
  logic [31:0] exp_q[$];
  logic [7:0] e_acc, e_m;
  logic [5:0] e_f;
  logic e_skip, e_ill;

  xma_core #(.ADDR_W(12)) uut (.CORE_CLK(clk), .RESET(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .BUSY(busy), .OP_DONE(op_done), .SKIP_TAKEN(skip_taken));

  initial begin
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; holds each phase until ready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= ~w;
    do @(posedge clk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // Read data is taken at the edge that ends the data phase
  always @(posedge clk) begin
    if (rd_dp && hready === 1'b1)
      cmp_word(hrdata, exp_q.pop_front());
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic model(input logic [4:0] op, input logic [2:0] b);
    logic [8:0] d;
    logic [4:0] n;
    logic [7:0] dn, up;
    logic bv, bi, ov;
    bv = op == 5'h0b || op == 5'h0c;
    bi = bv & ~e_f[`XMA_FLG_C];
    d = {1'b0, e_acc} - {1'b0, e_m} - {8'h0, bi};
    n = {1'b0, e_acc[3:0]} - {1'b0, e_m[3:0]} - {4'h0, bi};
    ov = (e_acc[7] ^ e_m[7]) & (e_acc[7] ^ d[7]);
    dn = e_m - 8'h01;
    up = e_m + 8'h01;
    e_skip = (op == 5'h0f || op == 5'h10) ? dn == 8'h00 :
             (op == 5'h11 || op == 5'h12) ? up == 8'h00 :
             (op == 5'h15) ? e_m[b] : (op == 5'h16) && e_m != 8'h00;
    e_ill = op > 5'h17;
    case (op)
      5'h00: e_m = e_acc;
      5'h01: e_acc = e_acc | e_m;
      5'h02: e_m = e_acc | e_m;
      5'h03: e_m = {e_m[6:0], e_m[7]};
      5'h04: e_acc = {e_m[6:0], e_m[7]};
      5'h05: {e_f[`XMA_FLG_C], e_m} = {e_m, e_f[`XMA_FLG_C]};
      5'h06: {e_f[`XMA_FLG_C], e_acc} = {e_m, e_f[`XMA_FLG_C]};
      5'h07: e_m = {e_m[0], e_m[7:1]};
      5'h08: e_acc = {e_m[0], e_m[7:1]};
      5'h09: {e_m, e_f[`XMA_FLG_C]} = {e_f[`XMA_FLG_C], e_m};
      5'h0a: {e_acc, e_f[`XMA_FLG_C]} = {e_f[`XMA_FLG_C], e_m};
      5'h0b, 5'h0d: e_acc = d[7:0];
      5'h0c, 5'h0e: e_m = d[7:0];
      5'h0f: e_m = dn;
      5'h10: e_acc = dn;
      5'h11: e_m = up;
      5'h12: e_acc = up;
      5'h13: e_m = 8'hff;
      5'h14: e_m[b] = 1'b1;
      5'h17: e_m = {e_m[3:0], e_m[7:4]};
      default: ;
    endcase
    if (op == 5'h01 || op == 5'h02)
      e_f[`XMA_FLG_Z] = (op == 5'h01 ? e_acc : e_m) == 8'h00;
    if (op >= 5'h0b && op <= 5'h0e) begin
      e_f[`XMA_FLG_C] = ~d[8];
      e_f[`XMA_FLG_AC] = ~n[4];
      e_f[`XMA_FLG_OV] = ov;
      e_f[`XMA_FLG_SC] = d[7] ^ ov;
      e_f[`XMA_FLG_CZ] = (d[7:0] == 8'h00) & (~bv | e_f[`XMA_FLG_CZ]);
      e_f[`XMA_FLG_Z] = d[7:0] == 8'h00;
    end
  endtask

  initial begin
    logic [31:0] rn;
    logic [11:0] ad;
    logic [4:0] op;
    logic [2:0] b;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`XMA_OFF_ACC, 32'h0);
    rd(`XMA_OFF_FLAGS, 32'h0);
    wr(8'h18, 32'hffffffff);
    rd(8'h18, 32'h0);
    // Rounds 0..2 force operands onto the skip boundaries
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k <= 24; k++) begin
        op = k[4:0];
        rn = $random(seed);
        e_acc = rn[7:0];
        e_m = r == 0 ? 8'h01 : r == 1 ? 8'hff : r == 2 ? 8'h00 : rn[15:8];
        e_f = rn[21:16];
        b = rn[24:22];
        rn = $random(seed);
        ad = rn[11:0];
        wr(`XMA_OFF_ACC, {24'h0, e_acc});
        wr(`XMA_OFF_FLAGS, {26'h0, e_f});
        wr(`XMA_OFF_MADDR, {20'h0, ad});
        wr(`XMA_OFF_MDATA, {24'h0, e_m});
        model(op, b);
        wr(`XMA_OFF_CMD, {4'h0, ad, 5'h0, b, 3'h0, op});
        rd(`XMA_OFF_ACC, {24'h0, e_acc});
        rd(`XMA_OFF_FLAGS, {26'h0, e_f});
        rd(`XMA_OFF_MDATA, {24'h0, e_m});
        rd(`XMA_OFF_STATUS, {29'h0, e_ill, e_skip, 1'b0});
      end
    end
    // Two locations far apart: no banking, only the target changes
    wr(`XMA_OFF_MADDR, 32'h0);
    wr(`XMA_OFF_MDATA, 32'h11);
    wr(`XMA_OFF_MADDR, 32'h800);
    wr(`XMA_OFF_MDATA, 32'h22);
    wr(`XMA_OFF_CMD, {4'h0, 12'h800, 11'h0, 5'h13});
    rd(`XMA_OFF_MDATA, 32'hff);
    wr(`XMA_OFF_MADDR, 32'h0);
    rd(`XMA_OFF_MDATA, 32'h11);
    // Let the monitor take the last read before the run ends
    @(posedge clk);
    if (exp_q.size() != 0)
      error_cnt++;
    give_verdict();
  end
endmodule
